// ===== entry_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "trap_entry_cfg.svh"
module entry_addr_gen (
  trap_vec_if.agen tv
);
  logic [3:0] nib;
  always_comb begin
    case (tv.place)
      trap_entry_pkg::PL_MEMORY_AREA_ZERO: nib = `TEV_NIB_M0;
      trap_entry_pkg::PL_MEMORY_AREA_ONE: nib = `TEV_NIB_M1;
      trap_entry_pkg::PL_MEMORY_AREA_TWO: nib = `TEV_NIB_M2;
      trap_entry_pkg::PL_ONCHIP_RAM: nib = `TEV_NIB_ONCHIP_RAM;
      default:                 nib = `TEV_NIB_M0;
    endcase
    if (tv.place == trap_entry_pkg::PL_TOP) begin
      if (tv.sw) begin
        tv.addr = `TEV_TOP_SW + (32'(tv.idx[3:0]) << `TEV_SW_SH);
      end else begin
        tv.addr = `TEV_TOP_TRAP + (32'(tv.idx) << `TEV_TRAP_SH);
      end
    end else if (tv.sw) begin
      tv.addr = {nib, `TEV_BASE_SW + ({24'h00_0000, ~tv.idx[3:0]} << `TEV_SW_SH)};
    end else begin
      tv.addr = {nib, `TEV_BASE_TRAP - (28'(tv.idx) << `TEV_TRAP_SH)};
    end
  end
endmodule  // entry_addr_gen
`default_nettype wire

// ===== event_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "trap_entry_cfg.svh"
module event_arbiter (
  trap_vec_if.arb tv
);
  function automatic logic [4:0] prio_of(input logic [5:0] t, input logic [1:0] ts);
    case (t)
      `TEV_T_RESET:  prio_of = `TEV_P_RESET;
      `TEV_T_RSV61:  prio_of = `TEV_P_RSV61;
      `TEV_T_RANGE:  prio_of = `TEV_P_RANGE;
      `TEV_T_OVF:    prio_of = `TEV_P_OVF;
      `TEV_T_PARITY: prio_of = `TEV_P_PARITY;
      `TEV_T_EXT_INTERRUPT_LINE_1:   prio_of = `TEV_P_EXT_INTERRUPT_LINE_1;
      `TEV_T_EXT_INTERRUPT_LINE_2:   prio_of = `TEV_P_EXT_INTERRUPT_LINE_2;
      `TEV_T_EXT_INTERRUPT_LINE_3:   prio_of = `TEV_P_EXT_INTERRUPT_LINE_3;
      `TEV_T_EXT_INTERRUPT_LINE_4:   prio_of = `TEV_P_EXT_INTERRUPT_LINE_4;
      `TEV_T_IO3:    prio_of = `TEV_P_IO3;
      `TEV_T_IO1:    prio_of = `TEV_P_IO1;
      `TEV_T_IO2:    prio_of = `TEV_P_IO2;
      `TEV_T_TIMER:  prio_of = `TEV_P_TIMER + 5'({ts, 1'b0});
      `TEV_T_TRACE:  prio_of = `TEV_P_TRACE;
      `TEV_T_RSV56:  prio_of = `TEV_P_RSV56;
      default:       prio_of = `TEV_P_NONE;
    endcase
  endfunction

  logic [4:0] pr;
  // lowest priority number wins
  always_comb begin
    tv.win_any  = 1'b0;
    tv.win_num  = '0;
    tv.win_prio = `TEV_P_NONE;
    pr          = `TEV_P_NONE;
    for (int i = 0; i < 16; i++) begin
      pr = prio_of({`TEV_T_BASE, 4'(i)}, tv.tsel);
      if (tv.pend[i] && pr < tv.win_prio) begin
        tv.win_any  = 1'b1;
        tv.win_num  = {`TEV_T_BASE, 4'(i)};
        tv.win_prio = pr;
      end
    end
  end
endmodule  // event_arbiter
`default_nettype wire

// ===== irq_source.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// interrupt line model
// ----------------------------------------
// lines follow the request mask after an off-edge delay, unrelated to the clock
module irq_source (
  input  wire logic [6:0] req,
  output logic     [3:0] ext_int,
  output logic     [2:0] io_int
);
  initial begin
    ext_int = 4'h0;
    io_int  = 3'h0;
  end
  always @(req) begin
    #17;
    ext_int = req[3:0];
    io_int  = req[6:4];
  end
endmodule // irq_source
`default_nettype wire

// ===== trap_entry_cfg.svh
// Summary of operation
// - trap and exception entries lie four bytes apart, one branch each.
// - a conditional trap uses the same entry as the plain trap.
// - after reset the table sits at FFFF FF00 plus four times n.
// - base placement uses top nibble 0, 4, 8, C; trap 63 first.
// - trap 63 is the entry for an all-ones instruction word.
// - reset is trap 62, priority 0; trap 61 reserved at priority 1.
// - range, pointer, frame and privilege errors share trap 60, priority 2.
// - extended overflow trap 59 priority 3; parity error trap 58 priority 4.
// - external lines 1 to 4 use traps 53..50, priorities 7, 9, 11, 13.
// - pin interrupts: third trap 54/5, first 49/14, second 48/15.
// - timer uses trap 55 with priority 6, 8, 10 or 12.
// - trace is trap 57 priority 16; trap 56 reserved priority 17.
// - top placement: emulated entries 16 bytes apart from FFFF FE00.
// - base placement: do entry at 010C, add single ends at 01FC.
// - call or trap costs 1 cycle untaken, 2 plus latency taken.
// - emulated instruction costs 6 plus latency beyond 4.
// - return costs 4 plus latency beyond 2, plus pulled word cycles.
// - return adds precharge plus RAS-to-CAS only above two words.
`ifndef TRAP_ENTRY_CFG_SVH
`define TRAP_ENTRY_CFG_SVH
`define TEV_TOP_TRAP   32'hFFFF_FF00
`define TEV_TOP_SW     32'hFFFF_FE00
`define TEV_BASE_TRAP  28'h000_00FC
`define TEV_BASE_SW    28'h000_010C
`define TEV_NIB_M0     4'h0
`define TEV_NIB_M1     4'h4
`define TEV_NIB_M2     4'h8
`define TEV_NIB_ONCHIP_RAM   4'hC
`define TEV_TRAP_SH    2
`define TEV_SW_SH      4
`define TEV_T_BASE     2'h3
`define TEV_T_IO2      6'h30
`define TEV_T_IO1      6'h31
`define TEV_T_EXT_INTERRUPT_LINE_4     6'h32
`define TEV_T_EXT_INTERRUPT_LINE_3     6'h33
`define TEV_T_EXT_INTERRUPT_LINE_2     6'h34
`define TEV_T_EXT_INTERRUPT_LINE_1     6'h35
`define TEV_T_IO3      6'h36
`define TEV_T_TIMER    6'h37
`define TEV_T_RSV56    6'h38
`define TEV_T_TRACE    6'h39
`define TEV_T_PARITY   6'h3A
`define TEV_T_OVF      6'h3B
`define TEV_T_RANGE    6'h3C
`define TEV_T_RSV61    6'h3D
`define TEV_T_RESET    6'h3E
`define TEV_T_ONES     6'h3F
`define TEV_P_RESET    5'h00
`define TEV_P_RSV61    5'h01
`define TEV_P_RANGE    5'h02
`define TEV_P_OVF      5'h03
`define TEV_P_PARITY   5'h04
`define TEV_P_IO3      5'h05
`define TEV_P_TIMER    5'h06
`define TEV_P_EXT_INTERRUPT_LINE_1     5'h07
`define TEV_P_EXT_INTERRUPT_LINE_2     5'h09
`define TEV_P_EXT_INTERRUPT_LINE_3     5'h0B
`define TEV_P_EXT_INTERRUPT_LINE_4     5'h0D
`define TEV_P_IO1      5'h0E
`define TEV_P_IO2      5'h0F
`define TEV_P_TRACE    5'h10
`define TEV_P_RSV56    5'h11
`define TEV_P_NONE     5'h1F
`define TEV_PEND_RST   16'h4000
`define TEV_C_ONE      12'h001
`define TEV_C_TAKEN    12'h002
`define TEV_C_SW       12'h006
`define TEV_C_RET      12'h004
`define TEV_SW_FREE    8'h04
`define TEV_RET_FREE   8'h02
`define TEV_RAS_MIN    6'h02
`endif

// ===== trap_entry_pkg.sv
package trap_entry_pkg;
  typedef enum logic [2:0] {PL_TOP, PL_MEMORY_AREA_ZERO, PL_MEMORY_AREA_ONE, PL_MEMORY_AREA_TWO, PL_ONCHIP_RAM} place_t;
  typedef enum logic [2:0] {K_TRAP, K_CTRAP, K_CALL, K_SW, K_RET, K_ONES} kind_t;
  typedef enum logic {S_IDLE, S_EXEC} state_t;
endpackage

// ===== trap_entry_vector_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "trap_entry_cfg.svh"
module trap_entry_vector_unit #(
  parameter int LAT_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [2:0]       placement_sel,
  input  wire logic [1:0]       timer_prio_sel,
  input  wire logic [3:0]       ext_int,
  input  wire logic [2:0]       io_int,
  input  wire logic             timer_irq,
  input  wire logic             trace_exc,
  input  wire logic             parity_err,
  input  wire logic             ext_overflow,
  input  wire logic             range_err,
  input  wire logic             insn_valid,
  input  wire logic [2:0]       insn_kind,
  input  wire logic             cond_true,
  input  wire logic [5:0]       trap_num,
  input  wire logic [3:0]       sw_code,
  input  wire logic [LAT_W-1:0] read_lat,
  input  wire logic [3:0]       ras_pre,
  input  wire logic [3:0]       ras_cas,
  input  wire logic [5:0]       pull_words,
  input  wire logic [3:0]       bus_cycles,
  output logic                  insn_ready_q,
  output logic                  busy_q,
  output logic                  done_q,
  output logic [11:0]           cost_q,
  output logic                  entry_valid_q,
  output logic                  entry_sw_q,
  output logic [5:0]            entry_trap_q,
  output logic [4:0]            entry_prio_q,
  output logic [31:0]           entry_addr_q
);

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  trap_vec_if tv ();

  event_arbiter u_arb (
    .tv (tv.arb)
  );

  entry_addr_gen u_agen (
    .tv (tv.agen)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_s3_q;
  logic [6:0] pin_st_q;
  logic [6:0] pin_st_d;
  logic [6:0] pin_rise;

  // change counts once second and third stage agree
  always_comb begin
    pin_st_d = pin_st_q;
    pin_rise = '0;
    for (int i = 0; i < 7; i++) begin
      if (pin_s2_q[i] == pin_s3_q[i]) begin
        pin_st_d[i] = pin_s3_q[i];
        pin_rise[i] = pin_s3_q[i] & ~pin_st_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_st_q <= '0;
    end else begin
      pin_s1_q <= {io_int, ext_int};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_st_q <= pin_st_d;
    end
  end

  // ----------------------------------------------------------------
  // pending events
  // ----------------------------------------------------------------
  logic [15:0] pend_q;
  logic [15:0] pend_d;
  logic [15:0] pend_set;
  logic [15:0] pend_clr;
  logic [1:0]  tsel_q;
  logic        take_evt;

  always_comb begin
    pend_set = '0;
    pend_set[4'(`TEV_T_EXT_INTERRUPT_LINE_1)]   = pin_rise[0];
    pend_set[4'(`TEV_T_EXT_INTERRUPT_LINE_2)]   = pin_rise[1];
    pend_set[4'(`TEV_T_EXT_INTERRUPT_LINE_3)]   = pin_rise[2];
    pend_set[4'(`TEV_T_EXT_INTERRUPT_LINE_4)]   = pin_rise[3];
    pend_set[4'(`TEV_T_IO1)]    = pin_rise[4];
    pend_set[4'(`TEV_T_IO2)]    = pin_rise[5];
    pend_set[4'(`TEV_T_IO3)]    = pin_rise[6];
    pend_set[4'(`TEV_T_TIMER)]  = timer_irq;
    pend_set[4'(`TEV_T_TRACE)]  = trace_exc;
    pend_set[4'(`TEV_T_PARITY)] = parity_err;
    pend_set[4'(`TEV_T_OVF)]    = ext_overflow;
    pend_set[4'(`TEV_T_RANGE)]  = range_err;
    pend_clr = '0;
    if (take_evt) begin
      pend_clr[tv.win_num[3:0]] = 1'b1;
    end
    // a new event wins over the clear of the same bit
    pend_d = (pend_q & ~pend_clr) | pend_set;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_q <= `TEV_PEND_RST;
      tsel_q <= '0;
    end else begin
      pend_q <= pend_d;
      tsel_q <= timer_prio_sel;
    end
  end

  // ----------------------------------------------------------------
  // instruction cost
  // ----------------------------------------------------------------
  trap_entry_pkg::kind_t kind;
  logic        taken;
  logic [11:0] cost;
  logic [11:0] late;
  logic [11:0] pull;

  always_comb begin
    kind  = trap_entry_pkg::kind_t'(insn_kind);
    taken = 1'b1;
    late  = '0;
    pull  = '0;
    cost  = `TEV_C_TAKEN + 12'(read_lat);
    case (kind)
      trap_entry_pkg::K_CTRAP, trap_entry_pkg::K_CALL: begin
        taken = cond_true;
        if (!cond_true) begin
          cost = `TEV_C_ONE;
        end
      end
      trap_entry_pkg::K_SW: begin
        if (read_lat > LAT_W'(`TEV_SW_FREE)) begin
          late = 12'(read_lat - LAT_W'(`TEV_SW_FREE));
        end
        cost = `TEV_C_SW + late;
      end
      trap_entry_pkg::K_RET: begin
        taken = 1'b0;
        if (read_lat > LAT_W'(`TEV_RET_FREE)) begin
          late = 12'(read_lat - LAT_W'(`TEV_RET_FREE));
        end
        if (pull_words > `TEV_RAS_MIN) begin
          pull = 12'(ras_pre) + 12'(ras_cas);
        end
        pull = pull + 12'(pull_words * bus_cycles);
        cost = `TEV_C_RET + late + pull;
      end
      default: begin
        taken = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and outputs
  // ----------------------------------------------------------------
  trap_entry_pkg::state_t state_q;
  trap_entry_pkg::state_t state_d;
  trap_entry_pkg::place_t place_q;
  trap_entry_pkg::place_t ent_place_q;
  trap_entry_pkg::place_t ent_place_d;
  logic        acc;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        ent_q;
  logic        ent_d;
  logic        sw_q;
  logic        sw_d;
  logic [5:0]  num_q;
  logic [5:0]  num_d;
  logic        ready_d;
  logic        busy_d;
  logic        done_d;
  logic [11:0] cost_d;
  logic        evalid_d;
  logic        esw_d;
  logic [5:0]  etrap_d;
  logic [4:0]  eprio_d;
  logic [31:0] eaddr_d;

  assign acc      = insn_valid && insn_ready_q && state_q == trap_entry_pkg::S_IDLE;
  assign take_evt = state_q == trap_entry_pkg::S_IDLE && !insn_ready_q && tv.win_any;
  assign tv.pend  = pend_q;
  assign tv.tsel  = tsel_q;
  assign tv.place = place_q;
  assign tv.sw    = state_q == trap_entry_pkg::S_EXEC && sw_q;
  assign tv.idx   = state_q == trap_entry_pkg::S_EXEC ? num_q : tv.win_num;

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    ent_d       = ent_q;
    sw_d        = sw_q;
    num_d       = num_q;
    ent_place_d = ent_place_q;
    done_d      = 1'b0;
    cost_d      = cost_q;
    evalid_d    = 1'b0;
    esw_d       = entry_sw_q;
    etrap_d     = entry_trap_q;
    eprio_d     = entry_prio_q;
    eaddr_d     = entry_addr_q;
    case (state_q)
      trap_entry_pkg::S_IDLE: begin
        if (take_evt) begin
          evalid_d    = 1'b1;
          esw_d       = 1'b0;
          etrap_d     = tv.win_num;
          eprio_d     = tv.win_prio;
          eaddr_d     = tv.addr;
          ent_place_d = place_q;
        end else if (acc) begin
          cost_d = cost;
          ent_d  = taken && kind != trap_entry_pkg::K_CALL;
          sw_d   = kind == trap_entry_pkg::K_SW;
          num_d  = trap_num;
          if (kind == trap_entry_pkg::K_SW) begin
            num_d = {2'b00, sw_code};
          end else if (kind == trap_entry_pkg::K_ONES) begin
            num_d = `TEV_T_ONES;
          end
          if (cost == `TEV_C_ONE) begin
            done_d = 1'b1;
          end else begin
            state_d = trap_entry_pkg::S_EXEC;
            cnt_d   = cost - `TEV_C_TAKEN;
          end
        end
      end
      trap_entry_pkg::S_EXEC: begin
        if (cnt_q == '0) begin
          state_d  = trap_entry_pkg::S_IDLE;
          done_d   = 1'b1;
          evalid_d = ent_q;
          if (ent_q) begin
            esw_d       = sw_q;
            etrap_d     = num_q;
            eprio_d     = `TEV_P_NONE;
            eaddr_d     = tv.addr;
            ent_place_d = place_q;
          end
        end else begin
          cnt_d = cnt_q - `TEV_C_ONE;
        end
      end
      default: begin
        state_d = trap_entry_pkg::S_IDLE;
      end
    endcase
    busy_d  = state_d == trap_entry_pkg::S_EXEC;
    ready_d = state_d == trap_entry_pkg::S_IDLE && (pend_d & ~pend_clr) == '0;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q       <= trap_entry_pkg::S_IDLE;
      place_q       <= trap_entry_pkg::PL_TOP;
      ent_place_q   <= trap_entry_pkg::PL_TOP;
      cnt_q         <= '0;
      ent_q         <= 1'b0;
      sw_q          <= 1'b0;
      num_q         <= '0;
      insn_ready_q  <= 1'b0;
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
      cost_q        <= '0;
      entry_valid_q <= 1'b0;
      entry_sw_q    <= 1'b0;
      entry_trap_q  <= '0;
      entry_prio_q  <= `TEV_P_NONE;
      entry_addr_q  <= '0;
    end else begin
      state_q       <= state_d;
      place_q       <= trap_entry_pkg::place_t'(placement_sel);
      ent_place_q   <= ent_place_d;
      cnt_q         <= cnt_d;
      ent_q         <= ent_d;
      sw_q          <= sw_d;
      num_q         <= num_d;
      insn_ready_q  <= ready_d;
      busy_q        <= busy_d;
      done_q        <= done_d;
      cost_q        <= cost_d;
      entry_valid_q <= evalid_d;
      entry_sw_q    <= esw_d;
      entry_trap_q  <= etrap_d;
      entry_prio_q  <= eprio_d;
      entry_addr_q  <= eaddr_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_top_trap_addr: assert property (
    entry_valid_q && !entry_sw_q && ent_place_q == trap_entry_pkg::PL_TOP
    |-> entry_addr_q == 32'hFFFF_FF00 + {24'h00_0000, entry_trap_q, 2'b00})
    else $error("top trap entry address wrong");

  a_base_trap_addr: assert property (
    entry_valid_q && !entry_sw_q && ent_place_q != trap_entry_pkg::PL_TOP
    |-> entry_addr_q[27:0] == 28'h000_00FC - {20'h0_0000, entry_trap_q, 2'b00})
    else $error("base trap entry address wrong");

  a_top_sw_addr: assert property (
    entry_valid_q && entry_sw_q && ent_place_q == trap_entry_pkg::PL_TOP
    |-> entry_addr_q == 32'hFFFF_FE00 + {24'h00_0000, entry_trap_q[3:0], 4'h0})
    else $error("top emulation entry address wrong");

  a_base_sw_addr: assert property (
    entry_valid_q && entry_sw_q && ent_place_q != trap_entry_pkg::PL_TOP
    |-> entry_addr_q[27:0] == 28'h000_01FC - {20'h0_0000, entry_trap_q[3:0], 4'h0})
    else $error("base emulation entry address wrong");

  a_reset_prio: assert property (
    entry_valid_q && entry_trap_q == 6'h3E && entry_prio_q != 5'h1F
    |-> entry_prio_q == 5'h00)
    else $error("reset entry priority wrong");

  a_untaken_one: assert property (
    acc && kind == trap_entry_pkg::K_CTRAP && !cond_true
    |=> done_q && !entry_valid_q)
    else $error("untaken trap not one cycle");

  a_taken_trap: assert property (
    acc && kind == trap_entry_pkg::K_CTRAP && cond_true && read_lat == '0
    |=> !done_q ##1 done_q && entry_trap_q == $past(trap_num, 2))
    else $error("taken trap entry or timing wrong");

  a_ones_entry: assert property (
    acc && kind == trap_entry_pkg::K_ONES && read_lat == '0
    |-> ##2 entry_valid_q && entry_trap_q == 6'h3F)
    else $error("all-ones entry wrong");

  a_sw_cost: assert property (
    acc && kind == trap_entry_pkg::K_SW && read_lat == LAT_W'(7)
    |=> cost_q == 12'h009)
    else $error("emulation cost wrong");

  a_ret_cost: assert property (
    acc && kind == trap_entry_pkg::K_RET && read_lat == '0 && pull_words == 6'h02
    |=> cost_q == 12'h004 + 12'($past(bus_cycles) * 2))
    else $error("return cost wrong");

endmodule  // trap_entry_vector_unit
`default_nettype wire

// ===== trap_entry_vector_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module trap_entry_vector_unit_tb;
  logic        clk_sys, reset, insn_valid, cond_true;
  logic        timer_irq, trace_exc, parity_err, ext_overflow, range_err;
  logic [2:0]  placement_sel, insn_kind, io_int;
  logic [1:0]  timer_prio_sel;
  logic [3:0]  ext_int, sw_code, ras_pre, ras_cas, bus_cycles;
  logic [5:0]  trap_num, pull_words, entry_trap_q;
  logic [7:0]  read_lat;
  logic [6:0]  irq_req;
  logic        insn_ready_q, busy_q, done_q, entry_valid_q, entry_sw_q;
  logic [11:0] cost_q;
  logic [4:0]  entry_prio_q;
  logic [31:0] entry_addr_q;
  logic [43:0] eq[$];
  logic [11:0] cq[$];
  int          num_errors = 0;
  int          checked = 0;
  int          ord[7] = '{6, 0, 1, 2, 3, 4, 5};
  logic [5:0]  itrap[7] = '{6'd54, 6'd53, 6'd52, 6'd51, 6'd50, 6'd49, 6'd48};
  logic [4:0]  iprio[7] = '{5'd5, 5'd7, 5'd9, 5'd11, 5'd13, 5'd14, 5'd15};

  trap_entry_vector_unit #(.LAT_W(8)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .placement_sel(placement_sel),
    .timer_prio_sel(timer_prio_sel), .ext_int(ext_int), .io_int(io_int),
    .timer_irq(timer_irq), .trace_exc(trace_exc), .parity_err(parity_err),
    .ext_overflow(ext_overflow), .range_err(range_err), .insn_valid(insn_valid),
    .insn_kind(insn_kind), .cond_true(cond_true), .trap_num(trap_num),
    .sw_code(sw_code), .read_lat(read_lat), .ras_pre(ras_pre), .ras_cas(ras_cas),
    .pull_words(pull_words), .bus_cycles(bus_cycles), .insn_ready_q(insn_ready_q),
    .busy_q(busy_q), .done_q(done_q), .cost_q(cost_q), .entry_valid_q(entry_valid_q),
    .entry_sw_q(entry_sw_q), .entry_trap_q(entry_trap_q), .entry_prio_q(entry_prio_q),
    .entry_addr_q(entry_addr_q));
  irq_source irq_u (.req(irq_req), .ext_int(ext_int), .io_int(io_int));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_addr(input logic sw, input logic [5:0] n);
    logic [3:0] nib;
    nib = (placement_sel == 3'h2) ? 4'h4 : (placement_sel == 3'h3) ? 4'h8 :
          (placement_sel == 3'h4) ? 4'hC : 4'h0;
    if (placement_sel == 3'h0) begin
      return sw ? 32'hFFFF_FE00 + {n, 4'h0} : 32'hFFFF_FF00 + {n, 2'h0};
    end
    return {nib, 28'h0} | (sw ? 32'h0000_010C + {6'hF - n, 4'h0}
                              : 32'h0000_00FC - {n, 2'h0});
  endfunction

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic idle(input int n);
    @(negedge clk_sys);
    insn_valid = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic insn(input logic [2:0] k, input logic c, input logic [5:0] n,
                      input logic [3:0] sc);
    logic [11:0] cost;
    int          i;
    @(negedge clk_sys);
    insn_valid = 1'b1;
    insn_kind  = k;
    cond_true  = c;
    trap_num   = n;
    sw_code    = sc;
    read_lat   = 8'($urandom_range(9));
    pull_words = 6'($urandom_range(5));
    ras_pre    = 4'($urandom_range(3));
    ras_cas    = 4'($urandom_range(3));
    bus_cycles = 4'($urandom_range(1, 3));
    case (k)
      3'h1, 3'h2: cost = c ? 12'd2 + read_lat : 12'd1;
      3'h3: cost = 12'd6 + ((read_lat > 4) ? read_lat - 8'd4 : 8'd0);
      3'h4: cost = 12'd4 + ((read_lat > 2) ? read_lat - 8'd2 : 8'd0)
                 + ((pull_words > 2) ? ras_pre + ras_cas : 4'd0) + pull_words * bus_cycles;
      default: cost = 12'd2 + read_lat;
    endcase
    for (i = 0; i < 400 && insn_ready_q !== 1'b1; i++) @(negedge clk_sys);
    if (i == 400) begin
      num_errors++;
      wrap_up();
    end
    cq.push_back(cost);
    if (k == 3'h3) eq.push_back({1'b1, 2'b0, sc, 5'h1F, exp_addr(1'b1, {2'b0, sc})});
    else if (k == 3'h5) eq.push_back({1'b0, 6'h3F, 5'h1F, exp_addr(1'b0, 6'h3F)});
    else if (k == 3'h0 || (k == 3'h1 && c)) eq.push_back({1'b0, n, 5'h1F, exp_addr(1'b0, n)});
    @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(negedge clk_sys) begin
    if (reset === 1'b0 && done_q === 1'b1) begin
      `CHK("cost_q", (cq.size() ? cq.pop_front() : 12'hxxx), cost_q)
      `CHK("busy_q", 1'b0, busy_q)
    end
    if (reset === 1'b0 && entry_valid_q === 1'b1) begin
      `CHK("entry", (eq.size() ? eq.pop_front() : 44'hx),
           {entry_sw_q, entry_trap_q, entry_prio_q, entry_addr_q})
    end
  end

  // ----------------------------------------
  // clock, watchdog, stimulus
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [5:0] n;
    logic [6:0] m;
    void'($urandom(53));
    {reset, insn_valid, cond_true, timer_irq, trace_exc, parity_err} = 6'h20;
    {ext_overflow, range_err, placement_sel, timer_prio_sel, insn_kind} = 10'h0;
    {trap_num, sw_code, read_lat, ras_pre, ras_cas, pull_words, bus_cycles} = 36'h0;
    irq_req = 7'h0;
    eq.push_back({1'b0, 6'h3E, 5'h00, 32'hFFFF_FFF8});
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    for (int p = 0; p < 5; p++) begin
      idle(1);
      placement_sel = 3'(p);
      idle(3);
      n = 6'($urandom_range(63));
      insn(3'h0, 1'b0, n, 4'h0);
      insn(3'h1, 1'b1, n, 4'h0);
      insn(3'h1, 1'b0, n, 4'h0);
      insn(3'h2, 1'b1, n, 4'h0);
      insn(3'h2, 1'b0, n, 4'h0);
      insn(3'h5, 1'b0, n, 4'h0);
      for (int s = 0; s < 16; s++) insn(3'h3, 1'b0, n, 4'(s));
      repeat (3) insn(3'h4, 1'b0, n, 4'h0);
    end
    for (int t = 0; t < 4; t++) begin
      idle(1);
      timer_prio_sel = 2'(t);
      idle(2);
      {range_err, ext_overflow, parity_err, timer_irq, trace_exc} = 5'h1F;
      eq.push_back({1'b0, 6'd60, 5'd2, exp_addr(1'b0, 6'd60)});
      eq.push_back({1'b0, 6'd59, 5'd3, exp_addr(1'b0, 6'd59)});
      eq.push_back({1'b0, 6'd58, 5'd4, exp_addr(1'b0, 6'd58)});
      eq.push_back({1'b0, 6'd55, 5'(6 + 2 * t), exp_addr(1'b0, 6'd55)});
      eq.push_back({1'b0, 6'd57, 5'd16, exp_addr(1'b0, 6'd57)});
      @(negedge clk_sys);
      {range_err, ext_overflow, parity_err, timer_irq, trace_exc} = 5'h0;
      insn(3'h0, 1'b0, 6'd7, 4'h0);
      idle(10);
    end
    for (int r = 0; r < 4; r++) begin
      m = (r == 0) ? 7'h7F : 7'($urandom_range(127));
      irq_req = m;
      for (int i = 0; i < 7; i++)
        if (m[ord[i]]) eq.push_back({1'b0, itrap[i], iprio[i], exp_addr(1'b0, itrap[i])});
      idle(20);
      irq_req = 7'h0;
      idle(10);
    end
    idle(30);
    `CHK("queues_left", 32'h0, 32'(eq.size() + cq.size()))
    wrap_up();
  end
endmodule // trap_entry_vector_unit_tb
`default_nettype wire

// ===== trap_vec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface trap_vec_if;
  logic [15:0]                pend;
  logic [1:0]                 tsel;
  logic                       win_any;
  logic [5:0]                 win_num;
  logic [4:0]                 win_prio;
  trap_entry_pkg::place_t     place;
  logic                       sw;
  logic [5:0]                 idx;
  logic [31:0]                addr;
  modport arb  (input pend, tsel, output win_any, win_num, win_prio);
  modport agen (input place, sw, idx, output addr);
  modport top  (output pend, tsel, place, sw, idx, input win_any, win_num, win_prio, addr);
endinterface
`default_nettype wire
